// ### rx_clock_config_pkg.sv
// Constants, field layouts and carrier types shared by the receive and clock configuration registers.
package rx_clock_config_pkg;

    // ==========================================================================
    // Register offsets on the plain register port
    // ==========================================================================
    localparam logic [7:0] POST_DIV_OFFSET    = 8'h07;
    localparam logic [7:0] INPUT_CLK_OFFSET   = 8'h08;
    localparam logic [7:0] INPUT_TYPE_OFFSET  = 8'h09;
    localparam logic [7:0] INT_MASK_OFFSET    = 8'h0a;
    localparam logic [7:0] INT_STATUS_OFFSET  = 8'h0b;

    // ==========================================================================
    // Field positions of the post divider control register
    // ==========================================================================
    localparam int POSTSCALE_LSB   = 0;
    localparam int POSTSCALE_MSB   = 1;
    localparam int FRAC_BIT        = 2;
    localparam int MCLK_DIV_BIT    = 3;
    localparam int AUX_DIV_LSB     = 4;
    localparam int AUX_DIV_MSB     = 5;

    // ==========================================================================
    // Field positions of the input and clock source control register
    // ==========================================================================
    localparam int INSEL_LSB       = 0;
    localparam int INSEL_MSB       = 2;
    localparam int AUX_SRC_BIT     = 3;
    localparam int AUX_EN_BIT      = 4;
    localparam int FILL_BIT        = 5;
    localparam int IGNORE_BIT      = 6;
    localparam int MCLK_SRC_BIT    = 7;

    // ==========================================================================
    // Values after reset and implemented bits
    // ==========================================================================
    localparam logic [7:0] POST_DIV_RESET    = 8'h16;
    localparam logic [7:0] POST_DIV_USED     = 8'h3f;
    localparam logic [7:0] INPUT_CLK_RESET   = 8'h18;
    localparam logic [7:0] INPUT_TYPE_RESET  = 8'hff;
    localparam logic [7:0] INT_MASK_RESET    = 8'h00;
    localparam logic [7:0] INT_STATUS_RESET  = 8'h00;

    // ==========================================================================
    // Event bit order, shared by the mask and the status register
    // ==========================================================================
    localparam int EV_LOCK       = 0;
    localparam int EV_INVALID    = 1;
    localparam int EV_CSUD       = 2;
    localparam int EV_TRANS_ERR  = 3;
    localparam int EV_NON_AUDIO  = 4;
    localparam int EV_COPYRIGHT  = 5;
    localparam int EV_EMPHASIS   = 6;
    localparam int EV_RATE       = 7;

    // Effective clock distribution settings handed to the clock tree.
    typedef struct packed {
        logic [1:0] pll_postscale_select;
        logic       fractional_pll_enable;
        logic       master_clock_divider_select;
        logic       master_clock_source_select;
        logic [1:0] aux_clock_divider_select;
        logic       aux_clock_source_select;
        logic       aux_clock_pin_enable;
    } clock_config_t;

    // Receiver status flags watched for changes.
    typedef struct packed {
        logic       unlock;
        logic       invalid;
        logic       csud;
        logic       trans_err;
        logic       audio_n;
        logic       pcm_n;
        logic       cpy_n;
        logic       deemph;
        logic [1:0] rec_freq;
    } rx_flags_t;

endpackage : rx_clock_config_pkg

// ### rx_clock_config_regs.sv
// Receive path and clock distribution configuration registers with masked event interrupt.
`timescale 1ns/10ps
module rx_clock_config_regs #(
    parameter int SAMPLE_W = 24
) (
    input  wire logic                                 SYS_CLK_IN,
    input  wire logic                                 RST_B_IN,
    input  wire logic                                 CLK_EN_IN,
    // Register port.
    input  wire logic [7:0]                           REG_ADDR_IN,
    input  wire logic [7:0]                           REG_WDATA_IN,
    input  wire logic                                 REG_WR_IN,
    input  wire logic                                 REG_RD_IN,
    output logic      [7:0]                           REG_RDATA_OUT,
    // Receiver clocking mode and its automatic post-scale value.
    input  wire logic                                 RX_CLOCK_MODE_IN,
    input  wire logic [1:0]                           RX_AUTO_POSTSCALE_IN,
    // Receiver flags from the decoder, same clock.
    input  wire rx_clock_config_pkg::rx_flags_t       RX_FLAGS_IN,
    // Receive input pins, asynchronous.
    input  wire logic [7:0]                           RX_INPUTS_IN,
    // Decoded samples from the receiver.
    input  wire logic [SAMPLE_W-1:0]                  RX_SAMPLE_IN,
    input  wire logic                                 RX_SAMPLE_STROBE_IN,
    input  wire logic                                 RX_SAMPLE_CORRUPT_IN,
    // Outputs.
    output rx_clock_config_pkg::clock_config_t        CLOCK_CONFIG_OUT,
    output logic                                      AUX_CLOCK_PIN_OE_OUT,
    output logic      [2:0]                           RECEIVE_INPUT_SELECT_OUT,
    output logic      [7:0]                           RECEIVE_INPUT_TYPE_SELECT_OUT,
    output logic                                      RX_SELECTED_OUT,
    output logic      [SAMPLE_W-1:0]                  RX_SAMPLE_OUT,
    output logic                                      RX_SAMPLE_STROBE_OUT,
    output logic                                      INTERRUPT_OUT
);

    // ==========================================================================
    // Helper functions
    // ==========================================================================

    // A write strobe aimed at one register offset.
    function automatic logic write_hit(input logic       wr,
                                       input logic [7:0] addr,
                                       input logic [7:0] offset);
        write_hit = wr && (addr == offset);
    endfunction : write_hit

    // A flag that differs from its previous value.
    function automatic logic flag_changed(input logic now_v,
                                          input logic prev_v);
        flag_changed = now_v ^ prev_v;
    endfunction : flag_changed

    // A flag that has just risen.
    function automatic logic flag_rose(input logic now_v,
                                       input logic prev_v);
        flag_rose = now_v & ~prev_v;
    endfunction : flag_rose

    // ==========================================================================
    // Register storage
    // ==========================================================================
    logic [7:0]                       post_div_q;
    logic [7:0]                       input_clk_q;
    logic [7:0]                       input_type_q;
    logic [7:0]                       int_mask_q;
    logic [7:0]                       int_status_q;
    logic [7:0]                       int_status_d;
    logic [7:0]                       rdata_q;
    logic [7:0]                       read_value;

    // Event detection.
    rx_clock_config_pkg::rx_flags_t   flags_prev_q;
    logic                             primed_q;
    logic [7:0]                       events_raw;
    logic [7:0]                       events_gated;
    logic                             ignore_invalid_flag;

    // Receive input synchroniser and selection.
    logic [7:0]                       rx_pins_meta_q;
    logic [7:0]                       rx_pins_sync_q;
    logic                             rx_selected_q;

    // Sample fill path.
    logic [SAMPLE_W-1:0]              sample_q;
    logic                             sample_strobe_q;
    logic                             sample_bad;

    // ==========================================================================
    // Writable configuration registers
    // ==========================================================================

    // Post divider control: post-scale, fractional enable, master and aux dividers.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            post_div_q <= rx_clock_config_pkg::POST_DIV_RESET;
        end else if (CLK_EN_IN) begin
            if (write_hit(REG_WR_IN, REG_ADDR_IN, rx_clock_config_pkg::POST_DIV_OFFSET)) begin
                // Bits 7:6 are not implemented, so they are never stored.
                post_div_q <= REG_WDATA_IN & rx_clock_config_pkg::POST_DIV_USED;
            end
        end
    end

    // Input selection and clock source control.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            input_clk_q <= rx_clock_config_pkg::INPUT_CLK_RESET;
        end else if (CLK_EN_IN) begin
            if (write_hit(REG_WR_IN, REG_ADDR_IN, rx_clock_config_pkg::INPUT_CLK_OFFSET)) begin
                input_clk_q <= REG_WDATA_IN;
            end
        end
    end

    // Per-input circuit type, one bit for each receive input.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            input_type_q <= rx_clock_config_pkg::INPUT_TYPE_RESET;
        end else if (CLK_EN_IN) begin
            if (write_hit(REG_WR_IN, REG_ADDR_IN, rx_clock_config_pkg::INPUT_TYPE_OFFSET)) begin
                input_type_q <= REG_WDATA_IN;
            end
        end
    end

    // Interrupt mask; a one blocks the event entirely.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            int_mask_q <= rx_clock_config_pkg::INT_MASK_RESET;
        end else if (CLK_EN_IN) begin
            if (write_hit(REG_WR_IN, REG_ADDR_IN, rx_clock_config_pkg::INT_MASK_OFFSET)) begin
                int_mask_q <= REG_WDATA_IN;
            end
        end
    end

    // ==========================================================================
    // Effective clock distribution settings
    // ==========================================================================

    // The receiver clocking mode overrides the post-scale field but the written
    // value is kept, so software reads back what it wrote and regains it later.
    always_comb begin
        CLOCK_CONFIG_OUT = '0;
        if (RX_CLOCK_MODE_IN) begin
            CLOCK_CONFIG_OUT.pll_postscale_select = RX_AUTO_POSTSCALE_IN;
        end else begin
            CLOCK_CONFIG_OUT.pll_postscale_select =
                post_div_q[rx_clock_config_pkg::POSTSCALE_MSB:rx_clock_config_pkg::POSTSCALE_LSB];
        end
        // Zero means integer operation, the fraction is then ignored downstream.
        // Receiver mode never forces this bit; software must keep it set.
        CLOCK_CONFIG_OUT.fractional_pll_enable = post_div_q[rx_clock_config_pkg::FRAC_BIT];
        CLOCK_CONFIG_OUT.master_clock_source_select = input_clk_q[rx_clock_config_pkg::MCLK_SRC_BIT];
        // The master divider only means something while the second PLL clock is the source.
        if (!input_clk_q[rx_clock_config_pkg::MCLK_SRC_BIT]) begin
            CLOCK_CONFIG_OUT.master_clock_divider_select = post_div_q[rx_clock_config_pkg::MCLK_DIV_BIT];
        end
        CLOCK_CONFIG_OUT.aux_clock_source_select = input_clk_q[rx_clock_config_pkg::AUX_SRC_BIT];
        // The aux divider only acts while the first PLL clock drives the pin.
        if (!input_clk_q[rx_clock_config_pkg::AUX_SRC_BIT]) begin
            CLOCK_CONFIG_OUT.aux_clock_divider_select =
                post_div_q[rx_clock_config_pkg::AUX_DIV_MSB:rx_clock_config_pkg::AUX_DIV_LSB];
        end
        CLOCK_CONFIG_OUT.aux_clock_pin_enable = input_clk_q[rx_clock_config_pkg::AUX_EN_BIT];
    end

    // Pad enable for the aux clock pin; low leaves the pin tri-stated.
    assign AUX_CLOCK_PIN_OE_OUT = input_clk_q[rx_clock_config_pkg::AUX_EN_BIT];

    // Receive input routing and input circuit type.
    assign RECEIVE_INPUT_SELECT_OUT =
        input_clk_q[rx_clock_config_pkg::INSEL_MSB:rx_clock_config_pkg::INSEL_LSB];
    assign RECEIVE_INPUT_TYPE_SELECT_OUT = input_type_q;

    // ==========================================================================
    // Receive input pin selection
    // ==========================================================================

    // Two-stage synchroniser; the first stage feeds only the second.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            rx_pins_meta_q <= 8'h00;
            rx_pins_sync_q <= 8'h00;
        end else if (CLK_EN_IN) begin
            rx_pins_meta_q <= RX_INPUTS_IN;
            rx_pins_sync_q <= rx_pins_meta_q;
        end
    end

    // The selected input is registered so the receiver sees a clean level.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            rx_selected_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            rx_selected_q <= rx_pins_sync_q[RECEIVE_INPUT_SELECT_OUT];
        end
    end

    assign RX_SELECTED_OUT = rx_selected_q;

    // ==========================================================================
    // Corrupt and invalid sample handling
    // ==========================================================================

    assign ignore_invalid_flag = input_clk_q[rx_clock_config_pkg::IGNORE_BIT];

    // A sample is bad when corrupt, or invalid while the invalid flag is honoured.
    assign sample_bad = RX_SAMPLE_CORRUPT_IN | (RX_FLAGS_IN.invalid & ~ignore_invalid_flag);

    // Good samples pass; bad ones either repeat the last good one or become zero.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            sample_q <= '0;
        end else if (CLK_EN_IN) begin
            if (RX_SAMPLE_STROBE_IN) begin
                if (!sample_bad) begin
                    sample_q <= RX_SAMPLE_IN;
                end else if (input_clk_q[rx_clock_config_pkg::FILL_BIT]) begin
                    sample_q <= '0;
                end
                // Otherwise the register holds the last valid sample.
            end
        end
    end

    // The output strobe lags the input strobe by one cycle, in step with the sample register.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            sample_strobe_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            sample_strobe_q <= RX_SAMPLE_STROBE_IN;
        end
    end

    assign RX_SAMPLE_OUT        = sample_q;
    assign RX_SAMPLE_STROBE_OUT = sample_strobe_q;

    // ==========================================================================
    // Event detection
    // ==========================================================================

    // Previous flags for change detection. The first enabled cycle after reset
    // only primes them, so a flag already set at reset raises no false event.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            flags_prev_q <= '0;
            primed_q     <= 1'b0;
        end else if (CLK_EN_IN) begin
            flags_prev_q <= RX_FLAGS_IN;
            primed_q     <= 1'b1;
        end
    end

    // Raw events in status bit order.
    always_comb begin
        events_raw = 8'h00;
        if (primed_q) begin
            events_raw[rx_clock_config_pkg::EV_LOCK] =
                flag_changed(RX_FLAGS_IN.unlock, flags_prev_q.unlock);
            events_raw[rx_clock_config_pkg::EV_INVALID] =
                flag_rose(RX_FLAGS_IN.invalid, flags_prev_q.invalid) & ~ignore_invalid_flag;
            events_raw[rx_clock_config_pkg::EV_CSUD] =
                flag_rose(RX_FLAGS_IN.csud, flags_prev_q.csud);
            events_raw[rx_clock_config_pkg::EV_TRANS_ERR] =
                flag_rose(RX_FLAGS_IN.trans_err, flags_prev_q.trans_err);
            events_raw[rx_clock_config_pkg::EV_NON_AUDIO] =
                flag_changed(RX_FLAGS_IN.audio_n, flags_prev_q.audio_n) |
                flag_changed(RX_FLAGS_IN.pcm_n, flags_prev_q.pcm_n);
            events_raw[rx_clock_config_pkg::EV_COPYRIGHT] =
                flag_changed(RX_FLAGS_IN.cpy_n, flags_prev_q.cpy_n);
            events_raw[rx_clock_config_pkg::EV_EMPHASIS] =
                flag_changed(RX_FLAGS_IN.deemph, flags_prev_q.deemph);
            events_raw[rx_clock_config_pkg::EV_RATE] =
                flag_changed(RX_FLAGS_IN.rec_freq[1], flags_prev_q.rec_freq[1]) |
                flag_changed(RX_FLAGS_IN.rec_freq[0], flags_prev_q.rec_freq[0]);
        end
    end

    // The mask is applied before the status register, and again at the interrupt output.
    assign events_gated = events_raw & ~int_mask_q;

    // ==========================================================================
    // Interrupt status
    // ==========================================================================

    // Writing a one clears a bit; a new event in the same cycle wins.
    always_comb begin
        int_status_d = int_status_q;
        if (write_hit(REG_WR_IN, REG_ADDR_IN, rx_clock_config_pkg::INT_STATUS_OFFSET)) begin
            int_status_d = int_status_d & ~REG_WDATA_IN;
        end
        int_status_d = int_status_d | events_gated;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            int_status_q <= rx_clock_config_pkg::INT_STATUS_RESET;
        end else if (CLK_EN_IN) begin
            int_status_q <= int_status_d;
        end
    end

    // Only bits that passed the mask exist in status, so no second gating is
    // strictly needed; masking here too lets software silence a pending bit.
    assign INTERRUPT_OUT = |(int_status_q & ~int_mask_q);

    // ==========================================================================
    // Register read path
    // ==========================================================================

    // Read value decode; unmapped offsets read as zero.
    always_comb begin
        case (REG_ADDR_IN)
            rx_clock_config_pkg::POST_DIV_OFFSET: begin
                read_value = post_div_q;
            end
            rx_clock_config_pkg::INPUT_CLK_OFFSET: begin
                read_value = input_clk_q;
            end
            rx_clock_config_pkg::INPUT_TYPE_OFFSET: begin
                read_value = input_type_q;
            end
            rx_clock_config_pkg::INT_MASK_OFFSET: begin
                read_value = int_mask_q;
            end
            rx_clock_config_pkg::INT_STATUS_OFFSET: begin
                read_value = int_status_q;
            end
            default: begin
                read_value = 8'h00;
            end
        endcase
    end

    // Read data stands for exactly one cycle after the strobe, zero otherwise.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            rdata_q <= 8'h00;
        end else if (CLK_EN_IN) begin
            if (REG_RD_IN) begin
                rdata_q <= read_value;
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign REG_RDATA_OUT = rdata_q;

endmodule : rx_clock_config_regs

// ### rx_clock_config_checker.sv
// Concurrent checks on the ports of the configuration register bank.
`timescale 1ns/10ps
module rx_clock_config_checker (
    input wire logic                               SYS_CLK_IN,
    input wire logic                               RST_B_IN,
    input wire logic                               CLK_EN_IN,
    input wire logic [7:0]                         REG_ADDR_IN,
    input wire logic [7:0]                         REG_WDATA_IN,
    input wire logic                               REG_WR_IN,
    input wire logic                               REG_RD_IN,
    input wire logic [7:0]                         REG_RDATA_OUT,
    input wire logic                               RX_CLOCK_MODE_IN,
    input wire logic [1:0]                         RX_AUTO_POSTSCALE_IN,
    input wire rx_clock_config_pkg::clock_config_t CLOCK_CONFIG_OUT,
    input wire logic                               AUX_CLOCK_PIN_OE_OUT,
    input wire logic [2:0]                         RECEIVE_INPUT_SELECT_OUT,
    input wire logic [7:0]                         RECEIVE_INPUT_TYPE_SELECT_OUT,
    input wire logic                               INTERRUPT_OUT
);
    // ========
    // Accepted writes.
    // ========
    logic wr_src;
    logic wr_type;
    logic mask_all;
    assign wr_src   = REG_WR_IN && CLK_EN_IN && REG_ADDR_IN == 8'h08;
    assign wr_type  = REG_WR_IN && CLK_EN_IN && REG_ADDR_IN == 8'h09;
    assign mask_all = REG_WR_IN && CLK_EN_IN && REG_ADDR_IN == 8'h0a && REG_WDATA_IN == 8'hff;
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    AST_INSEL: assert property (wr_src |=> RECEIVE_INPUT_SELECT_OUT == $past(REG_WDATA_IN[2:0]))
        else $error("input select does not follow the write");
    AST_PIN_OE: assert property (wr_src |=> AUX_CLOCK_PIN_OE_OUT == $past(REG_WDATA_IN[4]))
        else $error("pin enable does not follow the write");
    AST_SOURCES: assert property (wr_src |=> CLOCK_CONFIG_OUT.aux_clock_source_select == $past(REG_WDATA_IN[3])
        && CLOCK_CONFIG_OUT.master_clock_source_select == $past(REG_WDATA_IN[7])) else $error("clock source wrong");
    AST_TYPE: assert property (wr_type |=> RECEIVE_INPUT_TYPE_SELECT_OUT == $past(REG_WDATA_IN))
        else $error("input type does not follow the write");
    AST_TYPE_HOLD: assert property (!wr_type |=> $stable(RECEIVE_INPUT_TYPE_SELECT_OUT))
        else $error("input type changed without a write");
    AST_AUTO: assert property (RX_CLOCK_MODE_IN |-> CLOCK_CONFIG_OUT.pll_postscale_select == RX_AUTO_POSTSCALE_IN)
        else $error("post-scale ignores receiver mode");
    AST_MDIV: assert property (CLOCK_CONFIG_OUT.master_clock_source_select |-> !CLOCK_CONFIG_OUT.master_clock_divider_select)
        else $error("master divider used with oscillator source");
    AST_ADIV: assert property (CLOCK_CONFIG_OUT.aux_clock_source_select |-> CLOCK_CONFIG_OUT.aux_clock_divider_select == 2'b00)
        else $error("aux divider used with oscillator source");
    AST_READ: assert property (REG_RD_IN && CLK_EN_IN && REG_ADDR_IN == 8'h09
        |=> REG_RDATA_OUT == $past(RECEIVE_INPUT_TYPE_SELECT_OUT)) else $error("read data wrong");
    AST_MASK_ALL: assert property (mask_all |=> !INTERRUPT_OUT)
        else $error("interrupt high with every event masked");
endmodule : rx_clock_config_checker

bind rx_clock_config_regs rx_clock_config_checker rx_clock_config_checker_inst (.*);

// ### rx_clock_config_regs_tb.sv
// Self-checking bench for the receive and clock configuration registers.
`timescale 1ns/10ps
module rx_clock_config_regs_tb;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, mode = 1'b0, stb = 1'b0, bad = 1'b0, en = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ins = 8'h00, rdata, itype;
    logic [1:0] auto_ps = 2'b01;
    logic [23:0] smp = 24'h000000, smp_o;
    logic [2:0] insel;
    logic oe, sel_pin, stb_o, irq;
    rx_clock_config_pkg::rx_flags_t flags = '0;
    rx_clock_config_pkg::clock_config_t cfg;
    int err_total = 0, check_count = 0;
    // ========
    // Design and clock.
    // ========
    rx_clock_config_regs rx_clock_config_regs_inst (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(en),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .RX_CLOCK_MODE_IN(mode), .RX_AUTO_POSTSCALE_IN(auto_ps), .RX_FLAGS_IN(flags), .RX_INPUTS_IN(ins),
        .RX_SAMPLE_IN(smp), .RX_SAMPLE_STROBE_IN(stb), .RX_SAMPLE_CORRUPT_IN(bad), .CLOCK_CONFIG_OUT(cfg),
        .AUX_CLOCK_PIN_OE_OUT(oe), .RECEIVE_INPUT_SELECT_OUT(insel), .RECEIVE_INPUT_TYPE_SELECT_OUT(itype),
        .RX_SELECTED_OUT(sel_pin), .RX_SAMPLE_OUT(smp_o), .RX_SAMPLE_STROBE_OUT(stb_o), .INTERRUPT_OUT(irq));
    always #5 clk = ~clk;
    // ========
    // Shared tasks; each but chk ends 1 ns after an edge so registered outputs have landed.
    // ========
    task automatic chk(input logic [23:0] s, e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_chk
    task automatic send(input logic [23:0] s, input logic c, input logic [23:0] e);
        @(posedge clk) {stb, smp, bad} <= {1'b1, s, c};
        @(posedge clk) stb <= 1'b0;
        #1 chk(stb_o, 1'b1);
        chk(smp_o, e);
    endtask : send
    // Reset values of every register, plus one unmapped offset that must read zero.
    task automatic t_reset();
        logic [7:0] rv[6] = '{8'h16, 8'h18, 8'hff, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd_chk(8'h07 + i[7:0], rv[i]);
        end
        chk(cfg, 9'h143);
        chk(oe, 1'b1);
    endtask : t_reset
    // Field effects on the clock settings, every input select and the input types.
    task automatic t_regs();
        wr_reg(8'h07, 8'hff);
        rd_chk(8'h07, 8'h3f);
        wr_reg(8'h08, 8'h00);
        chk(cfg, 9'h1ec);
        wr_reg(8'h08, 8'h88);
        chk(cfg, 9'h1d2);
        wr_reg(8'h07, 8'h00);
        chk(cfg, 9'h012);
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'h08, 8'h10 | i[7:0]);
            @(posedge clk) ins <= 8'h01 << i;
            tick(4);
            chk(insel, i[2:0]);
            chk(sel_pin, 1'b1);
            @(posedge clk) ins <= ~(8'h01 << i);
            tick(4);
            chk(sel_pin, 1'b0);
        end
        wr_reg(8'h09, 8'h5a);
        chk(itype, 8'h5a);
        @(posedge clk) en <= 1'b0;
        wr_reg(8'h09, 8'h00);
        @(posedge clk) en <= 1'b1;
        rd_chk(8'h09, 8'h5a);
        wr_reg(8'h08, 8'h00);
    endtask : t_regs
    // Receiver mode takes the post-scale from hardware; software value still reads back.
    task automatic t_auto();
        wr_reg(8'h07, 8'h04);
        @(posedge clk) mode <= 1'b1;
        #1 chk(cfg.pll_postscale_select, 2'b01);
        @(posedge clk) auto_ps <= 2'b10;
        #1 chk(cfg.pll_postscale_select, 2'b10);
        rd_chk(8'h07, 8'h04);
        @(posedge clk) mode <= 1'b0;
        #1 chk(cfg.pll_postscale_select, 2'b00);
    endtask : t_auto
    // Each event in turn, then masking, mask after the fact and the ignored invalid flag.
    task automatic t_irq();
        int pos[8] = '{9, 8, 7, 6, 5, 3, 2, 0};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) flags <= 10'h001 << pos[i];
            tick(2);
            chk(irq, 1'b1);
            rd_chk(8'h0b, 8'h01 << i);
            @(posedge clk) flags <= '0;
            wr_reg(8'h0b, 8'hff);
            chk(irq, 1'b0);
        end
        wr_reg(8'h0a, 8'hff);
        @(posedge clk) flags <= 10'h200;
        tick(2);
        chk(irq, 1'b0);
        rd_chk(8'h0b, 8'h00);
        wr_reg(8'h0a, 8'h00);
        @(posedge clk) flags <= '0;
        tick(2);
        chk(irq, 1'b1);
        wr_reg(8'h0a, 8'h01);
        chk(irq, 1'b0);
        wr_reg(8'h0b, 8'hff);
        wr_reg(8'h0a, 8'h00);
        wr_reg(8'h08, 8'h40);
        @(posedge clk) flags <= 10'h100;
        tick(2);
        rd_chk(8'h0b, 8'h00);
    endtask : t_irq
    // Sample path with the invalid flag still high, then corrupt data in both fill modes.
    task automatic t_fill();
        send(24'h123456, 1'b0, 24'h123456);
        wr_reg(8'h08, 8'h00);
        send(24'h654321, 1'b0, 24'h123456);
        @(posedge clk) flags <= '0;
        send(24'habcdef, 1'b1, 24'h123456);
        wr_reg(8'h08, 8'h20);
        send(24'habcdef, 1'b1, 24'h000000);
        send(24'h0f0f0f, 1'b0, 24'h0f0f0f);
    endtask : t_fill
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // Reset for twelve cycles, then every scenario in order.
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_auto();
        t_irq();
        t_fill();
        report_and_stop();
    end
endmodule : rx_clock_config_regs_tb
